// *** ida_pkg.sv ***
// Package: register map and constants for the indirect data addressing unit
package ida_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] PTR2_LOW_ADDR = 12'h0FD9;
  localparam logic [11:0] PTR2_HIGH_ADDR = 12'h0FDA;
  localparam logic [11:0] PTR2_PLUSW_ADDR = 12'h0FDB;
  localparam logic [11:0] PTR2_PREINC_ADDR = 12'h0FDC;
  localparam logic [11:0] PTR2_POSTDEC_ADDR = 12'h0FDD;
  localparam logic [11:0] PTR2_POSTINC_ADDR = 12'h0FDE;
  localparam logic [11:0] PTR2_INDIRECT_ADDR = 12'h0FDF;
  localparam logic [11:0] BANK_SELECT_ADDR = 12'h0FE0;
  localparam logic [11:0] PTR1_LOW_ADDR = 12'h0FE1;
  localparam logic [11:0] PTR1_HIGH_ADDR = 12'h0FE2;
  localparam logic [11:0] PTR1_PLUSW_ADDR = 12'h0FE3;
  localparam logic [11:0] PTR1_PREINC_ADDR = 12'h0FE4;
  localparam logic [11:0] PTR1_POSTDEC_ADDR = 12'h0FE5;
  localparam logic [11:0] PTR1_POSTINC_ADDR = 12'h0FE6;
  localparam logic [11:0] PTR1_INDIRECT_ADDR = 12'h0FE7;
  localparam logic [11:0] PTR0_LOW_ADDR = 12'h0FE9;
  localparam logic [11:0] PTR0_HIGH_ADDR = 12'h0FEA;
  localparam logic [11:0] PTR0_PLUSW_ADDR = 12'h0FEB;
  localparam logic [11:0] PTR0_PREINC_ADDR = 12'h0FEC;
  localparam logic [11:0] PTR0_POSTDEC_ADDR = 12'h0FED;
  localparam logic [11:0] PTR0_POSTINC_ADDR = 12'h0FEE;
  localparam logic [11:0] PTR0_INDIRECT_ADDR = 12'h0FEF;
  // Special function region bounds
  localparam logic [11:0] SFR_REGION_LO = 12'h0EF4;
  localparam logic [11:0] SFR_REGION_HI = 12'h0FFF;
  localparam logic [3:0] PTR_HIGH_MASK = 4'h0F;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// *** ida_ptr_if.sv ***
// Interface: one pointer pair's write strobes and value
interface ida_ptr_if;
  logic wrLow;
  logic wrHigh;
  logic [7:0] wrData;
  logic [11:0] value;
  modport owner (input wrLow, input wrHigh, input wrData, output value);
  modport user (output wrLow, output wrHigh, output wrData, input value);
endinterface

// *** ida_ptr_pair.sv ***
// One 12-bit pointer pair made of a low and a masked high register
module ida_ptr_pair import ida_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register access
  ida_ptr_if.owner port
);
  logic [7:0] lowQ, lowD;
  logic [3:0] highQ, highD;

  always_comb begin
    lowD = lowQ;
    highD = highQ;
    if (port.wrLow) begin
      lowD = port.wrData;
    end
    if (port.wrHigh) begin
      highD = port.wrData[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lowQ <= PTR_RESET;
      highQ <= PTR_RESET[3:0];
    end else begin
      lowQ <= lowD;
      highQ <= highD;
    end
  end

  assign port.value = {highQ, lowQ};
endmodule // ida_ptr_pair

// *** ida_indirect_unit.sv ***
// Indirect addressing unit: pointer pairs, virtual operand redirect, region decode
// Notes on behaviour
// - Three pointer pairs 0..2, each an 8-bit low and an 8-bit high register of which four bits count.
// - An access to plain indirect operand n goes to the data byte addressed by pointer pair n; the plus, pre and post forms read as zero.
// - Virtual operand locations are decoded in the register region but have no storage.
// - Indirect targets use the full 12-bit pointer and ignore bank select and access bit.
// - The register region covers F00h..FFFh and EF4h..EFFh at the top of data memory.
// - Unused locations in the register region hold nothing and read as zero.
module ida_indirect_unit import ida_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Core access, address already resolved by the core
  input wire logic coreRd,
  input wire logic coreWr,
  input wire logic [11:0] coreAddr,
  input wire logic [7:0] coreWrData,
  output logic [7:0] coreRdData,
  // Data memory port
  output logic memRd,
  output logic memWr,
  output logic [11:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // Status
  output logic [7:0] bankSelect,
  output logic inRegRegion,
  output logic indirectHit
);
  // Register kinds in the pointer block around bank select
  typedef enum logic [3:0] {
    KIND_NONE = 4'h0,
    KIND_LOW = 4'h1,
    KIND_HIGH = 4'h2,
    KIND_INDIRECT = 4'h3,
    KIND_PLUSW = 4'h4,
    KIND_PREINC = 4'h5,
    KIND_POSTDEC = 4'h6,
    KIND_POSTINC = 4'h7,
    KIND_BANK = 4'h8
  } ida_kind_e;

  // Where a read takes its byte from
  typedef enum logic [1:0] {
    SRC_ZERO = 2'h0,
    SRC_UNIT = 2'h1,
    SRC_MEM = 2'h2
  } ida_src_e;

  // Pair storage and decode results
  ida_ptr_if ptrIf [3] ();
  logic [11:0] ptrVal [3];
  logic [7:0] bankQ, bankD;
  logic [7:0] rdDataQ, rdDataD;
  ida_kind_e kind;
  logic [1:0] ptrSel;
  logic [2:0] wrLowSel;
  logic [2:0] wrHighSel;
  logic [1:0] indSel;
  logic indHit;
  logic inTopBank;
  logic inSlice;
  logic regionHit;
  logic unitHit;
  logic [7:0] unitRd;
  ida_src_e rdSrc;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gPtr
      ida_ptr_pair uPair (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .port(ptrIf[g])
      );
      assign ptrVal[g] = ptrIf[g].value;
      assign ptrIf[g].wrData = coreWrData;
      assign ptrIf[g].wrLow = wrLowSel[g];
      assign ptrIf[g].wrHigh = wrHighSel[g];
    end
  endgenerate

  // Decode of the pointer block; the plus, pre and post forms are decoded so
  // that they stay apart from plain memory, but own no storage here and
  // therefore fall to the read-as-zero path
  always_comb begin
    kind = KIND_NONE;
    ptrSel = 2'h0;
    case (coreAddr)
      // Pair 2
      PTR2_LOW_ADDR: begin
        kind = KIND_LOW;
        ptrSel = 2'h2;
      end
      PTR2_HIGH_ADDR: begin
        kind = KIND_HIGH;
        ptrSel = 2'h2;
      end
      PTR2_PLUSW_ADDR: begin
        kind = KIND_PLUSW;
        ptrSel = 2'h2;
      end
      PTR2_PREINC_ADDR: begin
        kind = KIND_PREINC;
        ptrSel = 2'h2;
      end
      PTR2_POSTDEC_ADDR: begin
        kind = KIND_POSTDEC;
        ptrSel = 2'h2;
      end
      PTR2_POSTINC_ADDR: begin
        kind = KIND_POSTINC;
        ptrSel = 2'h2;
      end
      PTR2_INDIRECT_ADDR: begin
        kind = KIND_INDIRECT;
        ptrSel = 2'h2;
      end
      // Bank select
      BANK_SELECT_ADDR: begin
        kind = KIND_BANK;
        ptrSel = 2'h0;
      end
      // Pair 1
      PTR1_LOW_ADDR: begin
        kind = KIND_LOW;
        ptrSel = 2'h1;
      end
      PTR1_HIGH_ADDR: begin
        kind = KIND_HIGH;
        ptrSel = 2'h1;
      end
      PTR1_PLUSW_ADDR: begin
        kind = KIND_PLUSW;
        ptrSel = 2'h1;
      end
      PTR1_PREINC_ADDR: begin
        kind = KIND_PREINC;
        ptrSel = 2'h1;
      end
      PTR1_POSTDEC_ADDR: begin
        kind = KIND_POSTDEC;
        ptrSel = 2'h1;
      end
      PTR1_POSTINC_ADDR: begin
        kind = KIND_POSTINC;
        ptrSel = 2'h1;
      end
      PTR1_INDIRECT_ADDR: begin
        kind = KIND_INDIRECT;
        ptrSel = 2'h1;
      end
      // Pair 0
      PTR0_LOW_ADDR: begin
        kind = KIND_LOW;
        ptrSel = 2'h0;
      end
      PTR0_HIGH_ADDR: begin
        kind = KIND_HIGH;
        ptrSel = 2'h0;
      end
      PTR0_PLUSW_ADDR: begin
        kind = KIND_PLUSW;
        ptrSel = 2'h0;
      end
      PTR0_PREINC_ADDR: begin
        kind = KIND_PREINC;
        ptrSel = 2'h0;
      end
      PTR0_POSTDEC_ADDR: begin
        kind = KIND_POSTDEC;
        ptrSel = 2'h0;
      end
      PTR0_POSTINC_ADDR: begin
        kind = KIND_POSTINC;
        ptrSel = 2'h0;
      end
      PTR0_INDIRECT_ADDR: begin
        kind = KIND_INDIRECT;
        ptrSel = 2'h0;
      end
      default: begin
        kind = KIND_NONE;
        ptrSel = 2'h0;
      end
    endcase
  end

  // One-hot write strobes into the pairs; a pair write and an indirect
  // access in one cycle cannot meet, as the core issues one access a cycle
  always_comb begin
    wrLowSel = 3'h0;
    wrHighSel = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (coreWr && ptrSel == 2'(i)) begin
        wrLowSel[i] = kind == KIND_LOW;
        wrHighSel[i] = kind == KIND_HIGH;
      end
    end
  end

  // Only the plain indirect operand redirects; the other operand forms need
  // the core's W and increment path, which sits outside this unit
  assign indHit = kind == KIND_INDIRECT;
  assign indSel = ptrSel;

  // Region is the whole top bank plus the upper slice of the bank below
  assign inTopBank = coreAddr[11:8] == SFR_REGION_HI[11:8];
  assign inSlice = coreAddr[11:8] == SFR_REGION_LO[11:8] && coreAddr >= SFR_REGION_LO;
  assign regionHit = inTopBank || inSlice;

  // Registers owned here; anything else in the region but the indirect operands reads as zero
  always_comb begin
    unitHit = 1'b1;
    unitRd = READ_ZERO;
    case (kind)
      KIND_LOW: begin
        unitRd = ptrVal[ptrSel][7:0];
      end
      KIND_HIGH: begin
        unitRd = {4'h0, ptrVal[ptrSel][11:8]};
      end
      KIND_BANK: begin
        unitRd = bankQ;
      end
      default: begin
        unitHit = 1'b0;
        unitRd = READ_ZERO;
      end
    endcase
  end

  // Bank select serves the core's direct accesses, never the redirect
  always_comb begin
    bankD = bankQ;
    if (coreWr && kind == KIND_BANK) begin
      bankD = coreWrData;
    end
  end

  // Memory port: indirect goes to pointer target, normal memory passes,
  // other region locations are left to peripherals or read as zero
  always_comb begin
    memRd = 1'b0;
    memWr = 1'b0;
    memAddr = coreAddr;
    memWrData = coreWrData;
    if (indHit) begin
      memAddr = ptrVal[indSel];
      memRd = coreRd;
      memWr = coreWr;
    end else if (!regionHit) begin
      memRd = coreRd;
      memWr = coreWr;
    end
  end

  // Read source; the virtual operand itself never answers, its target does
  always_comb begin
    rdSrc = SRC_ZERO;
    if (indHit || !regionHit) begin
      rdSrc = SRC_MEM;
    end else if (unitHit) begin
      rdSrc = SRC_UNIT;
    end else begin
      rdSrc = SRC_ZERO;
    end
  end

  // Read data is registered: valid the cycle after coreRd and held until the
  // next read, so the core may pick it up late
  always_comb begin
    rdDataD = rdDataQ;
    if (coreRd) begin
      case (rdSrc)
        SRC_MEM: begin
          rdDataD = memRdData;
        end
        SRC_UNIT: begin
          rdDataD = unitRd;
        end
        default: begin
          rdDataD = READ_ZERO;
        end
      endcase
    end
  end

  // Bank select and read data are the only registers here; the pairs own theirs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bankQ <= BANK_RESET;
      rdDataQ <= READ_ZERO;
    end else begin
      bankQ <= bankD;
      rdDataQ <= rdDataD;
    end
  end

  assign coreRdData = rdDataQ;
  assign bankSelect = bankQ;
  assign inRegRegion = regionHit;
  assign indirectHit = indHit;
endmodule // ida_indirect_unit

// *** ida_mem_model.sv ***
// Partner model: data memory answering in the same cycle
module ida_mem_model (
  // Clock
  input wire logic clk_sys,
  // Memory port
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [11:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  logic [7:0] lastQ;
  always_ff @(posedge clk_sys) begin
    if (memWr) mem[memAddr] <= memWrData;
    if (memRd) lastQ <= memRdData;
  end
  // Unselected bus shows the inverse of the last byte, so stale data never matches
  assign memRdData = memRd ? mem[memAddr] : ~lastQ;
endmodule // ida_mem_model

// *** ida_indirect_unit_checker.sv ***
// Checker: port properties of the indirect addressing unit
module ida_indirect_unit_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Observed ports
  input wire logic coreRd,
  input wire logic coreWr,
  input wire logic [11:0] coreAddr,
  input wire logic [7:0] coreWrData,
  input wire logic [7:0] coreRdData,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [11:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] bankSelect,
  input wire logic [7:0] memRdData,
  input wire logic inRegRegion,
  input wire logic indirectHit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic acc;
  assign acc = coreRd || coreWr;
  AST_REGION: assert property (acc |-> inRegRegion == (coreAddr >= 12'hEF4))
    else $error("region decode");
  AST_HIT: assert property (acc |-> indirectHit == (coreAddr inside {12'hFEF, 12'hFE7, 12'hFDF}))
    else $error("operand decode");
  AST_DIRECT: assert property (acc && !inRegRegion |-> memAddr == coreAddr)
    else $error("direct address");
  AST_INDRD: assert property (coreRd && indirectHit |-> memRd)
    else $error("indirect read");
  AST_NOSTORE: assert property (coreWr && inRegRegion && !indirectHit |-> !memWr)
    else $error("region write leaked");
  AST_RDATA: assert property (coreRd && indirectHit |=> coreRdData == $past(memRdData))
    else $error("read data");
  AST_ZERO: assert property (coreRd && inRegRegion && coreAddr < 12'hF00 |=> coreRdData == 8'h00)
    else $error("unused not zero");
  AST_HIGH: assert property (coreRd && coreAddr inside {12'hFEA, 12'hFE2, 12'hFDA} |=> coreRdData[7:4] == 4'h0)
    else $error("high bits");
  AST_WDATA: assert property (memWr |-> memWrData == coreWrData)
    else $error("write data");
  AST_BANK: assert property (coreWr && coreAddr == 12'hFE0 |=> bankSelect == $past(coreWrData))
    else $error("bank select");
  cover property (coreRd && indirectHit);
  cover property (coreWr && coreAddr == 12'hFE0);
  cover property (coreWr && indirectHit);
  cover property (coreRd && !inRegRegion);
endmodule // ida_indirect_unit_checker
bind ida_indirect_unit ida_indirect_unit_checker chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .coreRd(coreRd),
  .coreWr(coreWr),
  .coreAddr(coreAddr),
  .coreWrData(coreWrData),
  .coreRdData(coreRdData),
  .memRd(memRd),
  .memWr(memWr),
  .memAddr(memAddr),
  .memWrData(memWrData),
  .bankSelect(bankSelect),
  .memRdData(memRdData),
  .inRegRegion(inRegRegion),
  .indirectHit(indirectHit)
);

// *** test_ida_indirect_unit.sv ***
// Testbench: pointer pairs, indirect redirect and region decode
module test_ida_indirect_unit import ida_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, coreRd = 0, coreWr = 0, pendQ = 0;
  logic memRd, memWr, inRegRegion, indirectHit;
  logic [11:0] coreAddr = '0, memAddr, ptr;
  logic [7:0] coreWrData = '0, coreRdData, memRdData, memWrData, bankSelect;
  logic [7:0] expQ [$];
  logic [11:0] regs [7] = '{12'hFE9, 12'hFEA, 12'hFE1, 12'hFE2, 12'hFD9, 12'hFDA, 12'hFE0};
  logic [11:0] un [6] = '{12'hEF4, 12'hEFF, 12'hFDB, 12'hFEE, 12'hFD4, 12'hF41};
  logic [31:0] seed = 32'h299e_13ea, r;
  int miscompares = 0, samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  ida_indirect_unit dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .coreRd(coreRd),
    .coreWr(coreWr),
    .coreAddr(coreAddr),
    .coreWrData(coreWrData),
    .coreRdData(coreRdData),
    .memRd(memRd),
    .memWr(memWr),
    .memAddr(memAddr),
    .memWrData(memWrData),
    .memRdData(memRdData),
    .bankSelect(bankSelect),
    .inRegRegion(inRegRegion),
    .indirectHit(indirectHit)
  );
  ida_mem_model mem (
    .clk_sys(clk_sys),
    .memRd(memRd),
    .memWr(memWr),
    .memAddr(memAddr),
    .memWrData(memWrData),
    .memRdData(memRdData)
  );
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Read ops queue their expected byte; back to back unless idle is called
  task automatic op(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    coreRd <= !w;
    coreWr <= w;
    coreAddr <= a;
    coreWrData <= d;
    if (!w) expQ.push_back(d);
  endtask
  task automatic idle();
    @(posedge clk_sys);
    coreRd <= 0;
    coreWr <= 0;
  endtask
  task automatic rst();
    rstn <= 0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1;
  endtask
  always @(posedge clk_sys) pendQ <= coreRd && rstn;
  always @(negedge clk_sys) if (pendQ) begin
    samples_checked++;
    if (coreRdData !== expQ[0]) begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, coreRdData, expQ[0]);
    end
    void'(expQ.pop_front());
  end
  task automatic results();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  initial begin
    rst();
    foreach (regs[i]) op(0, regs[i], 8'h00);
    for (int n = 0; n < 3; n++) begin
      r = xs();
      ptr = r[11:0] % 12'hEF4;
      op(1, 12'hFE0, r[31:24]);
      op(1, 12'(12'hFEA - 8 * n), {r[15:12], ptr[11:8]});
      op(1, 12'(12'hFE9 - 8 * n), ptr[7:0]);
      op(1, 12'(12'hFEF - 8 * n), r[23:16]);
      op(0, ptr, r[23:16]);
      op(0, 12'(12'hFEA - 8 * n), {4'h0, ptr[11:8]});
      op(0, 12'(12'hFE9 - 8 * n), ptr[7:0]);
      op(1, ptr, ~r[23:16]);
      op(0, 12'(12'hFEF - 8 * n), ~r[23:16]);
      op(0, 12'hFE0, r[31:24]);
    end
    foreach (un[i]) begin
      op(1, un[i], 8'hFF);
      op(0, un[i], 8'h00);
    end
    repeat (4) begin
      r = xs();
      op(1, r[11:0] % 12'hEF4, r[19:12]);
      op(0, r[11:0] % 12'hEF4, r[19:12]);
    end
    repeat (2) idle();
    rst();
    op(0, 12'hFE9, 8'h00);
    repeat (3) idle();
    results();
  end
endmodule // test_ida_indirect_unit
